// *** hdl/acs_pkg.sv ***
// Constants for the converter conversion sequencer
package acs_pkg;
    localparam int          NUM_CH        = 4;
    // Register byte offsets
    localparam logic [7:0]  OFF_MODE      = 8'h00;
    localparam logic [7:0]  OFF_STATUS    = 8'h04;
    localparam logic [7:0]  OFF_IOPORT    = 8'h08;
    localparam logic [7:0]  OFF_CONV_OFS  = 8'h0c;
    localparam logic [7:0]  OFF_CONV_GAIN = 8'h10;
    localparam logic [7:0]  OFF_CH_CFG    = 8'h20;
    localparam logic [7:0]  OFF_CH_DATA   = 8'h30;
    localparam logic [7:0]  OFF_CH_STAT   = 8'h40;
    localparam logic [7:0]  OFF_CH_OFS    = 8'h50;
    localparam logic [7:0]  OFF_CH_GAIN   = 8'h60;
    // Field positions
    localparam int          MODE_SEL_LSB  = 4;
    localparam int          CFG_CHOP_BIT  = 7;
    localparam int          CFG_EN_BIT    = 8;
    localparam int          CFG_BIP_BIT   = 9;
    localparam int          STAT_BUSY_BIT = 4;
    localparam int          CST_REFERENCE_MISSING_FLAG_BIT = 1;
    localparam int          OFS_SIGN_BIT  = 22;
    // Reset values
    localparam logic [9:0]  CFG_RST       = 10'h17f;
    localparam logic [23:0] CONV_OFS_RST  = 24'h000000;
    localparam logic [23:0] GAIN_RST      = 24'h200000;
    // Timing in master clock cycles
    localparam logic [15:0] SETTLE_SHORT  = 16'd43;
    localparam logic [15:0] SETTLE_LONG   = 16'd44;
    localparam logic [15:0] SETTLE_CHOP   = 16'd42;
    localparam logic [15:0] SCALE_CYC     = 16'd163;
    // Scaling constants
    localparam int          SHIFT_UNI     = 21;
    localparam int          SHIFT_BIP     = 22;
    localparam logic [23:0] BIP_MID       = 24'h800000;
    localparam logic [23:0] DATA_MAX      = 24'hffffff;
    localparam logic [21:0] OFS_MAG_MAX   = 22'h3fffff;

    typedef enum logic [2:0] {
        MODE_IDLE   = 3'b000,
        MODE_CONT   = 3'b001,
        MODE_SINGLE = 3'b010,
        MODE_ZS_SELF= 3'b011,
        MODE_ZS_SYS = 3'b100,
        MODE_FS_SYS = 3'b101
    } acs_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_WAIT    = 3'b001,
        ST_SETTLE1 = 3'b010,
        ST_SAMPLE1 = 3'b011,
        ST_SETTLE2 = 3'b100,
        ST_SAMPLE2 = 3'b101,
        ST_SCALE   = 3'b110
    } acs_state_e;
endpackage

// *** hdl/acs_sequencer.sv ***
// Conversion sequencer with calibration scaling and APB register file
//
// Contract
// - Chopped cycle starts with 43 or 44 settling cycles.
// - Sampling length comes from the channel filter word.
// - Chopped: 42 more settling cycles, then reversed-polarity sampling.
// - Chopped: 163-cycle scaling averages both results, scales, stores.
// - Unchopped: settle 43 or 44, sample once, scale 163.
// - Ready pin goes high during every scaling phase.
// - On data update set global and channel ready flags, ready pin low.
// - Continuous mode moves straight to the next enabled channel.
// - Conversion time and chopping are kept per channel.
// - Modulator clock runs at half the master clock.
// - Missing reference during conversion sets channel no-reference flag.
// - Sync enabled and sync pin low holds off the start of a mode request; later continuous conversions do not wait.
// - Raw result corrected by converter then channel calibration.
// - Unipolar formula with 200000h divisors.
// - Bipolar formula with 400000h divisor and 800000h offset.
// - Raw result is unsigned 24-bit.
// - Channel offset calibration is sign plus 22-bit magnitude.
// - Calibration end: update registers, all flags set, sync low, idle.
// - Calibration lasts the selected channel conversion time.
// - Zero-scale self-calibration shorts inputs, negative input sets level.
// - Chopping reverses the inputs on alternate samples.
`timescale 1ns/1ps
module acs_sequencer #(
    parameter int SAMPLE_UNIT = 128
) (
    input  wire logic        CLK_IN,
    input  wire logic        RST_B_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic [23:0] FILTER_RESULT_IN,
    input  wire logic        REF_LOW_IN,
    input  wire logic        HOLD_OR_GPIO1_PIN_IN,
    output logic             HOLD_OR_GPIO1_PIN_OUT,
    output logic             HOLD_OR_GPIO1_PIN_OE_OUT,
    output logic             RDY_B_OUT,
    output logic             MOD_CLK_OUT,
    output logic             SAMPLE_EN_OUT,
    output logic             CHOP_REV_OUT,
    output logic             SHORT_INPUTS_OUT,
    output logic      [1:0]  MUX_CH_OUT
);
    logic [9:0]              ch_cfg_r [acs_pkg::NUM_CH];
    logic [23:0]             ch_data_r [acs_pkg::NUM_CH];
    logic [22:0]             ch_ofs_r [acs_pkg::NUM_CH];
    logic [23:0]             ch_gain_r [acs_pkg::NUM_CH];
    logic [3:0]              rdy_r;
    logic [3:0]              reference_missing_flag_r;
    logic [23:0]             conv_ofs_r;
    logic [23:0]             conv_gain_r;
    logic                    sync_en_r;
    logic [2:0]              mode_r;
    logic [1:0]              sel_r;
    acs_pkg::acs_state_e     state_r;
    logic [15:0]             cnt_r;
    logic [23:0]             res1_r;
    logic [23:0]             res2_r;
    logic                    mclk_r;
    logic                    wr_go;
    logic                    rd_go;
    logic                    go;
    logic [1:0]              cur;
    logic [3:0]              en_vec;
    logic                    chop;
    logic                    bip;
    logic                    is_cal;
    logic [15:0]             samp_len;
    logic [15:0]             settle_len;
    logic [23:0]             scaled;
    logic [22:0]             ofs_new;
    logic [23:0]             gain_new;
    logic                    gain_ok;
    logic [31:0]             rd_val;
    logic                    rd_ok;

    assign wr_go = PSEL_IN && PENABLE_IN && !PREADY_OUT && PWRITE_IN;
    assign rd_go = PSEL_IN && PENABLE_IN && !PREADY_OUT && !PWRITE_IN;
    assign cur   = MUX_CH_OUT;
    assign chop  = ch_cfg_r[cur][acs_pkg::CFG_CHOP_BIT];
    assign bip   = ch_cfg_r[cur][acs_pkg::CFG_BIP_BIT];
    assign is_cal = mode_r >= acs_pkg::MODE_ZS_SELF;
    assign go    = !sync_en_r || HOLD_OR_GPIO1_PIN_IN;
    assign samp_len = 16'((32'(ch_cfg_r[cur][6:0]) + 32'd1) * 32'(SAMPLE_UNIT));
    // Odd or even settle to land on a modulator edge
    assign settle_len = mclk_r ? acs_pkg::SETTLE_LONG : acs_pkg::SETTLE_SHORT;

    always_comb begin
        for (int i = 0; i < acs_pkg::NUM_CH; i++) begin
            en_vec[i] = ch_cfg_r[i][acs_pkg::CFG_EN_BIT];
        end
    end

    // First enabled channel at or after a start point
    function automatic logic [1:0] find_en(input logic [1:0] start, input logic [3:0] en);
        logic [1:0] r;
        logic [1:0] c;
        r = start;
        for (int i = acs_pkg::NUM_CH - 1; i >= 0; i--) begin
            c = 2'(start + 2'(i));
            if (en[c]) begin
                r = c;
            end
        end
        return r;
    endfunction

    // Calibration and scaling arithmetic
    always_comb begin
        logic [23:0]        avg;
        logic signed [25:0] t1;
        logic signed [50:0] p1;
        logic signed [52:0] m;
        logic signed [52:0] ofs;
        logic signed [52:0] t2;
        logic signed [52:0] d;
        logic signed [78:0] p2;
        logic signed [78:0] r;
        logic [75:0]        q;
        avg = 24'h0;
        t1 = 26'sh0;
        p1 = 51'sh0;
        m = 53'sh0;
        ofs = 53'sh0;
        t2 = 53'sh0;
        d = 53'sh0;
        p2 = 79'sh0;
        r = 79'sh0;
        q = 76'h0;
        avg = chop ? 24'(({1'b0, res1_r} + {1'b0, res2_r}) >> 1) : res1_r;
        t1 = $signed({2'b00, avg}) - $signed({2'b00, conv_ofs_r});
        p1 = t1 * $signed({1'b0, conv_gain_r});
        if (bip) begin
            m = 53'(p1 >>> acs_pkg::SHIFT_BIP) + $signed({29'h0, acs_pkg::BIP_MID});
        end else begin
            m = 53'(p1 >>> acs_pkg::SHIFT_UNI);
        end
        ofs = $signed({31'h0, ch_ofs_r[cur][21:0]});
        if (ch_ofs_r[cur][acs_pkg::OFS_SIGN_BIT]) begin
            ofs = -ofs;
        end
        t2 = m - ofs;
        p2 = t2 * $signed({1'b0, ch_gain_r[cur]});
        r = p2 >>> acs_pkg::SHIFT_UNI;
        if (r < 0) begin
            scaled = 24'h0;
        end else if (r > $signed({55'h0, acs_pkg::DATA_MAX})) begin
            scaled = acs_pkg::DATA_MAX;
        end else begin
            scaled = r[23:0];
        end
        // Offset that brings the present input to zero scale
        d = bip ? (m - $signed({29'h0, acs_pkg::BIP_MID})) : m;
        if (d > $signed({31'h0, acs_pkg::OFS_MAG_MAX})) begin
            ofs_new = {1'b0, acs_pkg::OFS_MAG_MAX};
        end else if (d < -$signed({31'h0, acs_pkg::OFS_MAG_MAX})) begin
            ofs_new = {1'b1, acs_pkg::OFS_MAG_MAX};
        end else if (d < 0) begin
            ofs_new = {1'b1, 22'(-d)};
        end else begin
            ofs_new = {1'b0, d[21:0]};
        end
        // Gain that maps the present input to full scale
        gain_ok = t2 > 0;
        q = gain_ok ? ({31'h0, acs_pkg::DATA_MAX, 21'h0} / 76'(t2)) : 76'h0;
        gain_new = (q > 76'(acs_pkg::DATA_MAX)) ? acs_pkg::DATA_MAX : q[23:0];
    end

    // Configuration written only by software
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            sync_en_r <= 1'b0;
            for (int i = 0; i < acs_pkg::NUM_CH; i++) begin
                ch_cfg_r[i] <= acs_pkg::CFG_RST;
            end
        end else if (wr_go) begin
            if (PADDR_IN == acs_pkg::OFF_IOPORT) begin
                sync_en_r <= PWDATA_IN[0];
            end
            for (int i = 0; i < acs_pkg::NUM_CH; i++) begin
                if (PADDR_IN == acs_pkg::OFF_CH_CFG + 8'(4 * i)) begin
                    ch_cfg_r[i] <= PWDATA_IN[9:0];
                end
            end
        end
    end

    // Sequencer, mode, results, flags and calibration registers
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            state_r <= acs_pkg::ST_IDLE;
            mode_r <= acs_pkg::MODE_IDLE;
            sel_r <= 2'b00;
            cnt_r <= 16'h0;
            res1_r <= 24'h0;
            res2_r <= 24'h0;
            rdy_r <= 4'h0;
            reference_missing_flag_r <= 4'h0;
            conv_ofs_r <= acs_pkg::CONV_OFS_RST;
            conv_gain_r <= acs_pkg::GAIN_RST;
            RDY_B_OUT <= 1'b1;
            SAMPLE_EN_OUT <= 1'b0;
            CHOP_REV_OUT <= 1'b0;
            SHORT_INPUTS_OUT <= 1'b0;
            MUX_CH_OUT <= 2'b00;
            HOLD_OR_GPIO1_PIN_OE_OUT <= 1'b0;
            for (int i = 0; i < acs_pkg::NUM_CH; i++) begin
                ch_data_r[i] <= 24'h0;
                ch_ofs_r[i] <= 23'h0;
                ch_gain_r[i] <= acs_pkg::GAIN_RST;
            end
        end else begin
            // Reading channel data clears its ready flag
            for (int i = 0; i < acs_pkg::NUM_CH; i++) begin
                if (rd_go && PADDR_IN == acs_pkg::OFF_CH_DATA + 8'(4 * i)) begin
                    rdy_r[i] <= 1'b0;
                end
                if (wr_go && PADDR_IN == acs_pkg::OFF_CH_OFS + 8'(4 * i)) begin
                    ch_ofs_r[i] <= PWDATA_IN[22:0];
                end
                if (wr_go && PADDR_IN == acs_pkg::OFF_CH_GAIN + 8'(4 * i)) begin
                    ch_gain_r[i] <= PWDATA_IN[23:0];
                end
            end
            if (wr_go && PADDR_IN == acs_pkg::OFF_CONV_OFS) begin
                conv_ofs_r <= PWDATA_IN[23:0];
            end
            if (wr_go && PADDR_IN == acs_pkg::OFF_CONV_GAIN) begin
                conv_gain_r <= PWDATA_IN[23:0];
            end
            // No-reference flag, set wins over clear
            // Fixed count, since settle_len flips with the modulator phase
            if (state_r == acs_pkg::ST_SETTLE1 && cnt_r == acs_pkg::SETTLE_SHORT - 16'd2) begin
                reference_missing_flag_r[cur] <= 1'b0;
            end
            if (REF_LOW_IN && state_r > acs_pkg::ST_WAIT) begin
                reference_missing_flag_r[cur] <= 1'b1;
            end
            cnt_r <= cnt_r - 16'd1;
            if (wr_go && PADDR_IN == acs_pkg::OFF_MODE) begin
                // New mode request restarts the sequencer
                mode_r <= PWDATA_IN[2:0];
                sel_r <= PWDATA_IN[acs_pkg::MODE_SEL_LSB +: 2];
                state_r <= (PWDATA_IN[2:0] == acs_pkg::MODE_IDLE) ? acs_pkg::ST_IDLE : acs_pkg::ST_WAIT;
                HOLD_OR_GPIO1_PIN_OE_OUT <= 1'b0;
                SAMPLE_EN_OUT <= 1'b0;
                CHOP_REV_OUT <= 1'b0;
                SHORT_INPUTS_OUT <= 1'b0;
            end else begin
                case (state_r)
                    acs_pkg::ST_IDLE: begin
                        cnt_r <= 16'h0;
                    end
                    acs_pkg::ST_WAIT: begin
                        // Start when sync pin is released
                        if (go) begin
                            if (mode_r == acs_pkg::MODE_CONT && en_vec == 4'h0) begin
                                mode_r <= acs_pkg::MODE_IDLE;
                                state_r <= acs_pkg::ST_IDLE;
                            end else begin
                                MUX_CH_OUT <= (mode_r == acs_pkg::MODE_CONT) ? find_en(sel_r, en_vec) : sel_r;
                                SHORT_INPUTS_OUT <= mode_r == acs_pkg::MODE_ZS_SELF;
                                cnt_r <= settle_len - 16'd1;
                                state_r <= acs_pkg::ST_SETTLE1;
                            end
                        end
                    end
                    acs_pkg::ST_SETTLE1: begin
                        if (cnt_r == 16'd0) begin
                            // Calibration uses the channel conversion time
                            cnt_r <= samp_len - 16'd1;
                            SAMPLE_EN_OUT <= 1'b1;
                            state_r <= acs_pkg::ST_SAMPLE1;
                        end
                    end
                    acs_pkg::ST_SAMPLE1: begin
                        if (cnt_r == 16'd0) begin
                            res1_r <= FILTER_RESULT_IN;
                            SAMPLE_EN_OUT <= 1'b0;
                            if (chop) begin
                                CHOP_REV_OUT <= 1'b1;
                                cnt_r <= acs_pkg::SETTLE_CHOP - 16'd1;
                                state_r <= acs_pkg::ST_SETTLE2;
                            end else begin
                                // Single sample goes straight to scaling
                                RDY_B_OUT <= 1'b1;
                                cnt_r <= acs_pkg::SCALE_CYC - 16'd1;
                                state_r <= acs_pkg::ST_SCALE;
                            end
                        end
                    end
                    acs_pkg::ST_SETTLE2: begin
                        if (cnt_r == 16'd0) begin
                            cnt_r <= samp_len - 16'd1;
                            SAMPLE_EN_OUT <= 1'b1;
                            state_r <= acs_pkg::ST_SAMPLE2;
                        end
                    end
                    acs_pkg::ST_SAMPLE2: begin
                        if (cnt_r == 16'd0) begin
                            res2_r <= FILTER_RESULT_IN;
                            SAMPLE_EN_OUT <= 1'b0;
                            CHOP_REV_OUT <= 1'b0;
                            RDY_B_OUT <= 1'b1;
                            cnt_r <= acs_pkg::SCALE_CYC - 16'd1;
                            state_r <= acs_pkg::ST_SCALE;
                        end
                    end
                    acs_pkg::ST_SCALE: begin
                        if (cnt_r == 16'd0) begin
                            RDY_B_OUT <= 1'b0;
                            if (is_cal) begin
                                if (mode_r == acs_pkg::MODE_ZS_SELF) begin
                                    conv_ofs_r <= chop ? 24'(({1'b0, res1_r} + {1'b0, res2_r}) >> 1) : res1_r;
                                end else if (mode_r == acs_pkg::MODE_ZS_SYS) begin
                                    ch_ofs_r[cur] <= ofs_new;
                                end else if (gain_ok) begin
                                    ch_gain_r[cur] <= gain_new;
                                end
                                rdy_r <= 4'hf;
                                HOLD_OR_GPIO1_PIN_OE_OUT <= 1'b1;
                                SHORT_INPUTS_OUT <= 1'b0;
                                mode_r <= acs_pkg::MODE_IDLE;
                                state_r <= acs_pkg::ST_IDLE;
                            end else begin
                                // Store data and flag it ready
                                ch_data_r[cur] <= scaled;
                                rdy_r[cur] <= 1'b1;
                                if (mode_r == acs_pkg::MODE_CONT) begin
                                    MUX_CH_OUT <= find_en(2'(cur + 2'd1), en_vec);
                                    cnt_r <= settle_len - 16'd1;
                                    state_r <= acs_pkg::ST_SETTLE1;
                                end else begin
                                    mode_r <= acs_pkg::MODE_IDLE;
                                    state_r <= acs_pkg::ST_IDLE;
                                end
                            end
                        end
                    end
                    default: begin
                        state_r <= acs_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            mclk_r <= 1'b0;
            HOLD_OR_GPIO1_PIN_OUT <= 1'b0;
        end else begin
            mclk_r <= !mclk_r;
            HOLD_OR_GPIO1_PIN_OUT <= 1'b0;
        end
    end
    assign MOD_CLK_OUT = mclk_r;

    // Register read decode
    always_comb begin
        rd_val = 32'h0;
        rd_ok = 1'b1;
        case (PADDR_IN)
            acs_pkg::OFF_MODE:      rd_val = {26'h0, sel_r, 1'b0, mode_r};
            acs_pkg::OFF_STATUS:    rd_val = {27'h0, state_r != acs_pkg::ST_IDLE, rdy_r};
            acs_pkg::OFF_IOPORT:    rd_val = {31'h0, sync_en_r};
            acs_pkg::OFF_CONV_OFS:  rd_val = {8'h0, conv_ofs_r};
            acs_pkg::OFF_CONV_GAIN: rd_val = {8'h0, conv_gain_r};
            default: begin
                rd_ok = 1'b0;
                for (int i = 0; i < acs_pkg::NUM_CH; i++) begin
                    if (PADDR_IN == acs_pkg::OFF_CH_CFG + 8'(4 * i)) begin
                        rd_val = {22'h0, ch_cfg_r[i]};
                        rd_ok = 1'b1;
                    end
                    if (PADDR_IN == acs_pkg::OFF_CH_DATA + 8'(4 * i)) begin
                        rd_val = {8'h0, ch_data_r[i]};
                        rd_ok = 1'b1;
                    end
                    if (PADDR_IN == acs_pkg::OFF_CH_STAT + 8'(4 * i)) begin
                        rd_val = {30'h0, reference_missing_flag_r[i], rdy_r[i]};
                        rd_ok = 1'b1;
                    end
                    if (PADDR_IN == acs_pkg::OFF_CH_OFS + 8'(4 * i)) begin
                        rd_val = {9'h0, ch_ofs_r[i]};
                        rd_ok = 1'b1;
                    end
                    if (PADDR_IN == acs_pkg::OFF_CH_GAIN + 8'(4 * i)) begin
                        rd_val = {8'h0, ch_gain_r[i]};
                        rd_ok = 1'b1;
                    end
                end
            end
        endcase
    end

    // APB answer with one wait state
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h0;
        end else begin
            PREADY_OUT <= PSEL_IN && PENABLE_IN && !PREADY_OUT;
            PSLVERR_OUT <= PSEL_IN && PENABLE_IN && !PREADY_OUT && !rd_ok;
            PRDATA_OUT <= (rd_go && rd_ok) ? rd_val : 32'h0;
        end
    end
endmodule

// *** testbench/acs_sequencer_asserts.sv ***
// Port-level checks for the conversion sequencer
`timescale 1ns/1ps
module acs_sequencer_asserts #(parameter int SAMPLE_UNIT = 128) (
    input wire logic       CLK_IN,
    input wire logic       RST_B_IN,
    input wire logic       RDY_B_OUT,
    input wire logic       MOD_CLK_OUT,
    input wire logic       SAMPLE_EN_OUT,
    input wire logic       CHOP_REV_OUT,
    input wire logic       SHORT_INPUTS_OUT,
    input wire logic [1:0] MUX_CH_OUT,
    input wire logic       HOLD_OR_GPIO1_PIN_OE_OUT
);
    logic [15:0] cnt_r;
    always_ff @(posedge CLK_IN or negedge RST_B_IN)
        if (!RST_B_IN) cnt_r <= 16'h0000;
        else cnt_r <= SAMPLE_EN_OUT ? cnt_r + 16'h0001 : 16'h0000;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    a_mod_half_rate: assert property ($past(RST_B_IN) |-> MOD_CLK_OUT != $past(MOD_CLK_OUT)) else $error("no toggle");
    a_sample_len: assert property ($fell(SAMPLE_EN_OUT) |-> cnt_r != 0 && cnt_r % SAMPLE_UNIT == 0) else $error("len");
    a_rdy_high_scale: assert property ($fell(SAMPLE_EN_OUT) && !CHOP_REV_OUT && !SHORT_INPUTS_OUT |-> RDY_B_OUT[*8])
        else $error("ready low in scale");
    a_scale_len: assert property ($fell(SAMPLE_EN_OUT) && !CHOP_REV_OUT && !SHORT_INPUTS_OUT |-> ##163 $fell(RDY_B_OUT))
        else $error("scale length");
    a_chop_settle: assert property ($rose(CHOP_REV_OUT) |-> ##42 $rose(SAMPLE_EN_OUT)) else $error("second settle");
    a_rev_after_first: assert property ($rose(CHOP_REV_OUT) |-> $fell(SAMPLE_EN_OUT)) else $error("reversal");
    a_mux_stable: assert property (SAMPLE_EN_OUT |-> $stable(MUX_CH_OUT)) else $error("mux moved");
    a_sync_at_end: assert property ($rose(HOLD_OR_GPIO1_PIN_OE_OUT) |-> !SAMPLE_EN_OUT && !CHOP_REV_OUT)
        else $error("sync low early");
    cover property ($rose(CHOP_REV_OUT));
    cover property ($fell(RDY_B_OUT));
    cover property ($rose(HOLD_OR_GPIO1_PIN_OE_OUT));
endmodule
bind acs_sequencer acs_sequencer_asserts #(.SAMPLE_UNIT(SAMPLE_UNIT)) u_chk (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
    .RDY_B_OUT(RDY_B_OUT), .MOD_CLK_OUT(MOD_CLK_OUT), .SAMPLE_EN_OUT(SAMPLE_EN_OUT), .CHOP_REV_OUT(CHOP_REV_OUT),
    .SHORT_INPUTS_OUT(SHORT_INPUTS_OUT), .MUX_CH_OUT(MUX_CH_OUT), .HOLD_OR_GPIO1_PIN_OE_OUT(HOLD_OR_GPIO1_PIN_OE_OUT));

// *** testbench/acs_front_model.sv ***
// Front-end filter model returning one result per sampling interval
`timescale 1ns/1ps
module acs_front_model (
    input  wire logic        clk_in,
    input  wire logic        sample_en_in,
    input  wire logic        chop_rev_in,
    input  wire logic [23:0] val_a_in,
    input  wire logic [23:0] val_b_in,
    output logic      [23:0] result_out = 24'h000000
);
    always @(posedge clk_in)
        result_out <= sample_en_in ? (chop_rev_in ? val_b_in : val_a_in) : ~result_out;
endmodule

// *** testbench/acs_sequencer_test.sv ***
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`define CMP(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", n, e, s); end end
module acs_sequencer_test;
    logic        clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, hold = 1, refl = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwd = 32'h0, prd;
    logic        rdy, err, oe, rdy_b, samp, chop, shrt;
    logic [23:0] filt, va = 24'h0, vb = 24'h0, co, cho, r;
    logic [32:0] ew, exp_q[$];
    int          n_errors = 0, num_checks = 0, cyc = 0;
    wire         sync_pin = hold && !oe;
    always #5 clk = ~clk;
    acs_sequencer #(.SAMPLE_UNIT(2)) dut (.CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(err),
        .FILTER_RESULT_IN(filt), .REF_LOW_IN(refl), .HOLD_OR_GPIO1_PIN_IN(sync_pin), .HOLD_OR_GPIO1_PIN_OUT(),
        .HOLD_OR_GPIO1_PIN_OE_OUT(oe), .RDY_B_OUT(rdy_b), .MOD_CLK_OUT(), .SAMPLE_EN_OUT(samp),
        .CHOP_REV_OUT(chop), .SHORT_INPUTS_OUT(shrt), .MUX_CH_OUT());
    acs_front_model fe (.clk_in(clk), .sample_en_in(samp), .chop_rev_in(chop), .val_a_in(va), .val_b_in(vb),
        .result_out(filt));
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pwr, paddr, pwd} <= {1'b1, w, a, d};
        @(posedge clk) pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        {psel, pen} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) if (rdy === 1'b1 && pwr === 1'b0) begin
        ew = exp_q.pop_front();
        `CMP("read", ew, {err, prd})
    end
    always @(posedge clk) if (++cyc == 20000) begin
        n_errors++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'haea57003));
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h24, 33'h17f);
        rd(8'hfc, 33'h100000000);
        co = 24'($urandom_range(16'hffff, 0));
        xfer(1'b1, 8'h0c, {8'h0, co});
        for (int i = 0; i < 2; i++) begin
            va <= 24'($urandom_range(24'hdfffff, 24'h100000));
            vb <= 24'($urandom_range(24'hdfffff, 24'h100000));
            cho = 24'($urandom_range(16'hffff, 0));
            xfer(1'b1, 8'h50 + 8'(4 * i), {8'h0, cho});
            xfer(1'b1, 8'h20 + 8'(4 * i), i ? 32'h380 : 32'h100);
            xfer(1'b1, 8'h08, 32'(i));
            hold <= (i == 0);
            xfer(1'b1, 8'h00, 32'(2 + 16 * i));
            repeat (60) @(posedge clk);
            `CMP("sync hold", 1'b0, chop)
            hold <= 1'b1;
            refl <= i[0];
            for (int n = 0; n < 2000 && rdy_b !== 1'b1; n++) @(posedge clk);
            for (int n = 0; n < 2000 && rdy_b !== 1'b0; n++) @(posedge clk);
            refl <= 1'b0;
            r = i ? 24'((25'(va) + 25'(vb)) >> 1) : va;
            rd(8'h40 + 8'(4 * i), 33'(1 + 2 * i));
            rd(8'h30 + 8'(4 * i), {9'h0, i ? ((r - co) >> 1) + 24'h800000 - cho : r - co - cho});
        end
        xfer(1'b1, 8'h08, 32'h0);
        xfer(1'b1, 8'h00, 32'h3);
        repeat (10) @(posedge clk);
        `CMP("short", 1'b1, shrt)
        for (int n = 0; n < 2000 && oe !== 1'b1; n++) @(posedge clk);
        `CMP("sync pin", 1'b0, sync_pin)
        rd(8'h04, 33'h0f);
        rd(8'h0c, {9'h0, va});
        // Channel zero-scale system calibration first, then full-scale
        va <= va + 24'h001000;
        xfer(1'b1, 8'h00, 32'h4);
        for (int n = 0; n < 2000 && oe !== 1'b1; n++) @(posedge clk);
        rd(8'h50, 33'h001000);
        xfer(1'b1, 8'h00, 32'h5);
        for (int n = 0; n < 2000 && oe !== 1'b1; n++) @(posedge clk);
        rd(8'h60, 33'h200000);
        tally_and_finish();
    end
endmodule
